// file: inc/urxb_pkg.sv
// Constants for the receive buffer and status block of the serial port
package urxb_pkg;
    // Register offsets
    localparam int ADDR_W = 2;
    localparam logic [1:0] OFS_STAT_A = 2'h0;
    localparam logic [1:0] OFS_STAT_B = 2'h1;
    localparam logic [1:0] OFS_STAT_C = 2'h2;
    localparam logic [1:0] OFS_DATA = 2'h3;
    localparam int DATA_W = 8;
    // Status A fields
    localparam int A_RXDONE_BIT = 7;
    localparam int A_FERR_BIT = 4;
    localparam int A_OVR_BIT = 3;
    localparam int A_PERR_BIT = 2;
    // Control B fields
    localparam int B_RXIE_BIT = 7;
    localparam int B_RXON_BIT = 4;
    localparam int B_CSIZE2_BIT = 2;
    localparam int B_NINTH_RX_BIT = 1;
    localparam int B_NINTH_TX_BIT = 0;
    localparam logic [7:0] B_WR_MASK = 8'h95;
    localparam logic [7:0] B_RST = 8'h00;
    // Control C fields
    localparam int C_PAR_EN_BIT = 5;
    localparam int C_PAR_ODD_BIT = 4;
    localparam int C_STOP2_BIT = 3;
    localparam int C_CSIZE1_BIT = 2;
    localparam int C_CSIZE0_BIT = 1;
    localparam logic [7:0] C_WR_MASK = 8'h3e;
    localparam logic [7:0] C_RST = 8'h06;
    // Character size codes
    localparam logic [2:0] CSIZE_NINE = 3'h7;
    // Stored entry layout
    localparam int CHAR_W = 9;
    localparam int ENT_W = 12;
    localparam int E_OVR_BIT = 11;
    localparam int E_PERR_BIT = 10;
    localparam int E_FERR_BIT = 9;
    localparam int FIFO_DEPTH = 2;
endpackage

// file: rtl/urxb_fifo.sv
// Small receive FIFO holding characters with their status
`timescale 1ns/1ps
module urxb_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic full,
    output logic empty
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    ////////////////////////////////////////////////////////////////////
    // Pointer and count update; flush wins over everything
    always_comb begin
        do_push = push && !full;
        do_pop = pop && !empty;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (do_push) begin
                wp_nxt = (wp_r == PTR_LAST) ? '0 : wp_r + 1'b1;
            end
            if (do_pop) begin
                rp_nxt = (rp_r == PTR_LAST) ? '0 : rp_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_nxt = cnt_r + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage, one slot per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        always_ff @(posedge mclk) begin
            if (ce && do_push && !flush && wp_r == PW'(i)) begin
                mem_r[i] <= push_data;
            end
        end
    end

    assign head = mem_r[rp_r];
    assign full = (cnt_r == CNT_FULL);
    assign empty = (cnt_r == '0);
endmodule // urxb_fifo

// file: rtl/urxb_top.sv
// Receive buffer, status flags and parity check of the serial port
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps

// Contract
// - Reading the data register advances the FIFO to the next character.
// - Receive-complete flag is one exactly while unread characters are stored.
// - Clearing receiver enable flushes the buffer, dropping receive-complete to zero.
// - Interrupt is requested while receive-complete and its enable are both set.
// - Error flags travel with their character; software reads status before data.
// - Software writes never change error flags; software writes them as zero.
// - Frame, overrun and parity errors raise no interrupt.
// - Frame error is zero for a high first stop bit, one for low.
// - Only the first stop bit is checked, whatever the stop-bit setting.
// - Overrun when buffer full, shift register waiting and new start detected.
// - Overrun state clears when a frame moves from shift register to buffer.
// - Parity error reads zero while parity checking is disabled.
// - Upper parity mode bit enables checking; lower bit picks odd or even.
// - Parity is checked over data bits at reception and stored with character.
// - Disable acts at once: frame in progress dropped, pin released, buffer lost.
// - Unused upper data bits read as zero for sizes below eight.
// - A frame enters the buffer at its first stop bit; second ignored.
module urxb_top #(
    parameter int DEPTH = urxb_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [urxb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [urxb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [urxb_pkg::DATA_W-1:0] reg_rdata,
    input wire logic frame_valid,
    input wire logic [urxb_pkg::CHAR_W-1:0] frame_data,
    input wire logic frame_stop_bit,
    input wire logic frame_parity_bit,
    input wire logic start_detect,
    output logic rx_enable,
    output logic rx_irq,
    output logic tx_ninth_bit,
    output logic [2:0] char_size_sel,
    output logic [1:0] parity_mode_sel,
    output logic stop_bit_count_sel
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    // Control registers, read answer and request
    logic [7:0] ctrl_b_r, ctrl_b_nxt;
    logic [7:0] ctrl_c_r, ctrl_c_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    // Hold stage for a frame that found the buffer full
    logic pend_r, pend_nxt;
    logic [urxb_pkg::ENT_W-1:0] pend_ent_r, pend_ent_nxt;
    logic ovr_r, ovr_nxt;
    // Format decode and entry build
    logic [2:0] csize;
    logic [urxb_pkg::CHAR_W-1:0] char_mask;
    logic par_exp, par_err;
    logic [urxb_pkg::ENT_W-1:0] frame_ent;
    logic rx_on, fv;
    // FIFO handshake and register decode
    logic fifo_push, fifo_pop, fifo_full, fifo_empty, flush;
    logic [urxb_pkg::ENT_W-1:0] fifo_in, head;
    logic rd_data, wr_b, wr_c;
    logic has_data;

    ////////////////////////////////////////////////////////////////////
    // Frame format decode
    // Size code is split over both control registers; codes 4 to 6 are
    // reserved and behave as their low two bits
    assign csize = {ctrl_b_r[urxb_pkg::B_CSIZE2_BIT],
                    ctrl_c_r[urxb_pkg::C_CSIZE1_BIT:urxb_pkg::C_CSIZE0_BIT]};
    assign rx_on = ctrl_b_r[urxb_pkg::B_RXON_BIT];

    // Data mask for short characters
    // Sizes 5 to 8 keep that many low bits; nine-bit mode keeps all nine,
    // so the unused upper bits never reach the buffer or the read port
    always_comb begin
        if (csize == urxb_pkg::CSIZE_NINE) begin
            char_mask = 9'h1ff;
        end else begin
            char_mask = {1'b0, 8'hff >> (2'h3 - csize[1:0])};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Parity check and entry build at frame arrival
    // The verdict is taken with the format in force at arrival, so a later
    // change of the parity mode cannot rewrite an entry already stored;
    // the read side still hides it while checking is off.
    // Only the first stop bit is looked at, whatever the stop-bit setting.
    always_comb begin
        par_exp = (^(frame_data & char_mask)) ^ ctrl_c_r[urxb_pkg::C_PAR_ODD_BIT];
        par_err = ctrl_c_r[urxb_pkg::C_PAR_EN_BIT] && (par_exp != frame_parity_bit);
        frame_ent = '0;
        frame_ent[urxb_pkg::CHAR_W-1:0] = frame_data & char_mask;
        frame_ent[urxb_pkg::E_PERR_BIT] = par_err;
        frame_ent[urxb_pkg::E_FERR_BIT] = ~frame_stop_bit;
    end

    // Frames only count while the receiver is on
    // A frame landing on the edge that drops the enable is swept out by the
    // flush one edge later
    assign fv = frame_valid && rx_on;
    assign flush = !rx_on;

    ////////////////////////////////////////////////////////////////////
    // Shift register hold stage and overrun tracking
    // The stage stands in for the receive shift register: a frame that finds
    // both slots taken waits here and a newer frame replaces it. A start bit
    // seen while it waits marks the loss; the mark rides in with the held
    // frame and is cleared by that move.
    always_comb begin
        // Held frame goes first so arrival order is kept
        fifo_push = !fifo_full && (pend_r || fv);
        fifo_in = pend_r ? pend_ent_r : frame_ent;
        fifo_in[urxb_pkg::E_OVR_BIT] = pend_r ? ovr_r : 1'b0;
        pend_nxt = pend_r && fifo_full;
        pend_ent_nxt = pend_ent_r;
        ovr_nxt = ovr_r;
        if (fv) begin
            // Newest frame sits in the shift register until a slot frees
            pend_ent_nxt = frame_ent;
            pend_nxt = pend_r || fifo_full;
        end
        if (pend_r && !fifo_full) begin
            ovr_nxt = 1'b0;
        end
        // Loss: both slots full, one waiting, another starting
        if (start_detect && rx_on && pend_r && fifo_full) begin
            ovr_nxt = 1'b1;
        end
        // Switching off drops the waiting frame and its mark
        if (flush) begin
            pend_nxt = 1'b0;
            ovr_nxt = 1'b0;
        end
    end

    // Hold stage registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            pend_r <= 1'b0;
            pend_ent_r <= '0;
            ovr_r <= 1'b0;
        end else if (ce) begin
            pend_r <= pend_nxt;
            pend_ent_r <= pend_ent_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive FIFO with status stored beside each character
    // Each entry: character in the low nine bits, then frame, parity and
    // overrun marks; the flush empties it in one edge while the receiver
    // is off
    urxb_fifo #(
        .WIDTH(urxb_pkg::ENT_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .flush(flush),
        .push(fifo_push),
        .push_data(fifo_in),
        .pop(fifo_pop),
        .head(head),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    ////////////////////////////////////////////////////////////////////
    // Buffer contents as software sees them
    // The flush lands one edge after the enable drops; gating here keeps the
    // complete flag and the status bits low in that gap cycle and drops the request at its end,
    // so nothing stale is shown or requested once the receiver is off.
    assign has_data = !fifo_empty && rx_on;

    ////////////////////////////////////////////////////////////////////
    // Register access decode
    // Status A and the data offset take no writes: a write there does
    // nothing, which keeps the error flags out of software's reach.
    // Both strobes at once never happen; if they do, both act and the read returns the value from before the write.
    always_comb begin
        rd_data = 1'b0;
        wr_b = 1'b0;
        wr_c = 1'b0;
        if (reg_addr == urxb_pkg::OFS_DATA) begin
            rd_data = reg_rd;
        end else if (reg_addr == urxb_pkg::OFS_STAT_B) begin
            wr_b = reg_wr;
        end else if (reg_addr == urxb_pkg::OFS_STAT_C) begin
            wr_c = reg_wr;
        end
    end

    // Data read pops only when something is stored
    assign fifo_pop = rd_data && has_data;

    ////////////////////////////////////////////////////////////////////
    // Control registers; status A writes are dropped
    // Read-only and reserved bits are masked on write; reserved ones read zero, the ninth receive bit reads from the head entry
    always_comb begin
        ctrl_b_nxt = ctrl_b_r;
        ctrl_c_nxt = ctrl_c_r;
        if (wr_b) begin
            ctrl_b_nxt = reg_wdata & urxb_pkg::B_WR_MASK;
        end
        if (wr_c) begin
            ctrl_c_nxt = reg_wdata & urxb_pkg::C_WR_MASK;
        end
        // Error flags live only in the FIFO and the hold stage, so no write reaches them
    end

    // Reset acts whatever the clock enable; otherwise state moves with it
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_b_r <= urxb_pkg::B_RST;
            ctrl_c_r <= urxb_pkg::C_RST;
        end else if (ce) begin
            ctrl_b_r <= ctrl_b_nxt;
            ctrl_c_r <= ctrl_c_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the strobe
    // Status, ninth bit and data all come from the head entry, so a data
    // read moves every one of them on to the next character at once.
    // Outside the answer cycle the port reads zero.
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            if (reg_addr == urxb_pkg::OFS_STAT_A) begin
                rdata_nxt[urxb_pkg::A_RXDONE_BIT] = has_data;
                rdata_nxt[urxb_pkg::A_FERR_BIT] =
                    has_data && head[urxb_pkg::E_FERR_BIT];
                rdata_nxt[urxb_pkg::A_OVR_BIT] =
                    has_data && head[urxb_pkg::E_OVR_BIT];
                rdata_nxt[urxb_pkg::A_PERR_BIT] = has_data &&
                    head[urxb_pkg::E_PERR_BIT] &&
                    ctrl_c_r[urxb_pkg::C_PAR_EN_BIT];
            end else if (reg_addr == urxb_pkg::OFS_STAT_B) begin
                rdata_nxt = ctrl_b_r;
                rdata_nxt[urxb_pkg::B_NINTH_RX_BIT] = has_data && head[8];
            end else if (reg_addr == urxb_pkg::OFS_STAT_C) begin
                rdata_nxt = ctrl_c_r;
            end else begin
                // Empty buffer reads as zero
                if (has_data) begin
                    rdata_nxt = head[7:0] & char_mask[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive-complete interrupt, level while data remains
    // Global masking sits outside; the request stays high until the buffer
    // is read empty, its enable is cleared or the receiver is switched off
    always_comb begin
        irq_nxt = ctrl_b_r[urxb_pkg::B_RXIE_BIT] && has_data;
        // Error flags deliberately feed no request
    end

    // Answer and request registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_r <= '0;
            irq_r <= 1'b0;
        end else if (ce) begin
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from registers
    // Format fields feed the recovery logic, which must drop any frame in
    // progress and release the input pin while the enable output is low;
    // the stop-bit setting is passed on but never used here
    assign reg_rdata = rdata_r;
    assign rx_irq = irq_r;
    assign rx_enable = ctrl_b_r[urxb_pkg::B_RXON_BIT];
    assign tx_ninth_bit = ctrl_b_r[urxb_pkg::B_NINTH_TX_BIT];
    assign char_size_sel = {ctrl_b_r[urxb_pkg::B_CSIZE2_BIT],
                            ctrl_c_r[urxb_pkg::C_CSIZE1_BIT:urxb_pkg::C_CSIZE0_BIT]};
    assign parity_mode_sel = ctrl_c_r[urxb_pkg::C_PAR_EN_BIT:urxb_pkg::C_PAR_ODD_BIT];
    assign stop_bit_count_sel = ctrl_c_r[urxb_pkg::C_STOP2_BIT];
endmodule // urxb_top

// file: sim/uart_rx_buffer_status_bench.sv
// Self-checking bench for the receive buffer and status block
`timescale 1ns/1ps
module uart_rx_buffer_status_bench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic send = 1'b0;
    logic [8:0] s_data = 9'h000;
    logic s_stop = 1'b1;
    logic s_odd = 1'b0;
    logic s_bad = 1'b0;
    logic s_start = 1'b0;
    logic [7:0] reg_rdata;
    logic [8:0] frame_data;
    logic frame_valid, frame_stop_bit, frame_parity_bit, start_detect;
    logic rx_enable, rx_irq, tx_ninth_bit, stop_bit_count_sel;
    logic [2:0] char_size_sel;
    logic [1:0] parity_mode_sel;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    // Format, stop bit, parity fault, expected status per row
    logic [7:0] cv [6] = '{8'h26, 8'h36, 8'h36, 8'h06, 8'h0e, 8'h0e};
    logic sv [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic bv [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0] av [6] = '{8'h94, 8'h80, 8'h84, 8'h80, 8'h80, 8'h90};
    urxb_top dut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
        .frame_data(frame_data), .frame_stop_bit(frame_stop_bit),
        .frame_parity_bit(frame_parity_bit), .start_detect(start_detect), .rx_enable(rx_enable),
        .rx_irq(rx_irq), .tx_ninth_bit(tx_ninth_bit), .char_size_sel(char_size_sel),
        .parity_mode_sel(parity_mode_sel), .stop_bit_count_sel(stop_bit_count_sel));
    urxb_far_end far (.mclk(mclk), .rst(rst), .send(send), .s_data(s_data), .s_stop(s_stop),
        .s_odd(s_odd), .s_bad(s_bad), .s_start(s_start), .frame_valid(frame_valid),
        .frame_data(frame_data), .frame_stop_bit(frame_stop_bit),
        .frame_parity_bit(frame_parity_bit), .start_detect(start_detect));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            $display("[FAIL] run time expected below 3000 seen 3000");
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read strobe then sample the single answer cycle
    task automatic rd(input logic [1:0] a, input string what, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask
    // Frame from the far end, or a bare start bit
    task automatic snd(input logic [8:0] d, input logic stp, input logic bad, input logic st);
        @(posedge mclk);
        send <= !st;
        s_data <= d;
        s_stop <= stp;
        s_bad <= bad;
        s_start <= st;
        @(posedge mclk);
        send <= 1'b0;
        s_start <= 1'b0;
    endtask
    task automatic t_basic();
        rd(2'h1, "ctrl b reset", 8'h00);
        rd(2'h2, "ctrl c reset", 8'h06);
        wr(2'h1, 8'h90);
        snd(9'h05a, 1'b1, 1'b0, 1'b0);
        rd(2'h0, "status full", 8'h80);
        chk("irq set", 8'h01, {7'h0, rx_irq});
        rd(2'h3, "data", 8'h5a);
        rd(2'h0, "status empty", 8'h00);
        chk("irq clear", 8'h00, {7'h0, rx_irq});
        rd(2'h3, "empty data", 8'h00);
        rd(2'h0, "status still empty", 8'h00);
        $display("t_basic done");
    endtask
    task automatic t_errors();
        for (int i = 0; i < 6; i++) begin
            wr(2'h2, cv[i]);
            s_odd <= cv[i][4];
            snd(9'h0c3, sv[i], bv[i], 1'b0);
            wr(2'h0, 8'h00);
            rd(2'h0, "error status", av[i]);
            rd(2'h3, "error data", 8'hc3);
        end
        $display("t_errors done");
    endtask
    task automatic t_overrun();
        snd(9'h011, 1'b1, 1'b0, 1'b0);
        snd(9'h022, 1'b1, 1'b0, 1'b0);
        snd(9'h033, 1'b1, 1'b0, 1'b0);
        snd(9'h000, 1'b1, 1'b0, 1'b1);
        rd(2'h0, "first status", 8'h80);
        rd(2'h3, "first data", 8'h11);
        rd(2'h0, "second status", 8'h80);
        rd(2'h3, "second data", 8'h22);
        rd(2'h0, "held status", 8'h88);
        rd(2'h3, "held data", 8'h33);
        snd(9'h044, 1'b1, 1'b0, 1'b0);
        rd(2'h0, "after overrun", 8'h80);
        rd(2'h3, "fourth data", 8'h44);
        $display("t_overrun done");
    endtask
    task automatic t_sizes();
        wr(2'h1, 8'h95);
        snd(9'h1a5, 1'b1, 1'b0, 1'b0);
        rd(2'h1, "ninth bit", 8'h97);
        chk("size and tx ninth", 8'h0f, {4'h0, tx_ninth_bit, char_size_sel});
        rd(2'h3, "nine bit data", 8'ha5);
        wr(2'h1, 8'h90);
        wr(2'h2, 8'h00);
        snd(9'h0ff, 1'b1, 1'b0, 1'b0);
        rd(2'h3, "five bit data", 8'h1f);
        wr(2'h2, 8'h06);
        $display("t_sizes done");
    endtask
    task automatic t_disable();
        ce <= 1'b0;
        wr(2'h1, 8'h80);
        ce <= 1'b1;
        rd(2'h1, "frozen ctrl b", 8'h90);
        snd(9'h055, 1'b1, 1'b0, 1'b0);
        snd(9'h066, 1'b1, 1'b0, 1'b0);
        wr(2'h1, 8'h80);
        rd(2'h0, "flushed", 8'h00);
        chk("irq off", 8'h00, {7'h0, rx_irq});
        chk("rx enable off", 8'h00, {7'h0, rx_enable});
        snd(9'h077, 1'b1, 1'b0, 1'b0);
        rd(2'h0, "dropped frame", 8'h00);
        rd(2'h3, "disabled data", 8'h00);
        wr(2'h1, 8'h90);
        rd(2'h0, "re-enabled", 8'h00);
        $display("t_disable done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_basic();
        t_errors();
        t_overrun();
        t_sizes();
        t_disable();
        close_out();
    end
endmodule // uart_rx_buffer_status_bench

// file: sim/urxb_chk_sva.sv
// Assertion checker for the receive buffer and status block
`timescale 1ns/1ps
module urxb_chk #(
    parameter int DEPTH = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [urxb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [urxb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [urxb_pkg::DATA_W-1:0] reg_rdata,
    input wire logic frame_valid,
    input wire logic rx_enable,
    input wire logic rx_irq,
    input wire logic [2:0] char_size_sel,
    input wire logic [1:0] parity_mode_sel,
    input wire logic stop_bit_count_sel
);
    logic ie_r;
    logic ie_nxt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadow of the receive interrupt enable
    always_comb begin
        ie_nxt = ie_r;
        if (rst) ie_nxt = 1'b0;
        else if (ce && reg_wr && reg_addr == urxb_pkg::OFS_STAT_B) ie_nxt = reg_wdata[7];
    end
    always_ff @(posedge mclk) begin
        ie_r <= ie_nxt;
    end
    ////////////////////////////////////////////////////////////////////////////////
    receiver_enable_bit_follow_a: assert property (ce && reg_wr && reg_addr == urxb_pkg::OFS_STAT_B
        |=> rx_enable == $past(reg_wdata[4])) else $error("receiver enable not taken");
    noirq_off_a: assert property (!rx_enable |=> !rx_irq)
        else $error("request while receiver off");
    irq_gate_a: assert property (!$past(ie_r) |-> !rx_irq)
        else $error("request without enable");
    irq_frame_a: assert property (ce && frame_valid && rx_enable && ie_r && !reg_wr
        |-> ##2 rx_irq) else $error("no request after frame");
    irq_hold_a: assert property (rx_irq && !$past(reg_rd) && !$past(reg_wr)
        |=> rx_irq) else $error("request dropped without read");
    cfg_c_a: assert property (ce && reg_wr && reg_addr == urxb_pkg::OFS_STAT_C
        |=> parity_mode_sel == $past(reg_wdata[5:4]) && stop_bit_count_sel == $past(reg_wdata[3])
        && char_size_sel[1:0] == $past(reg_wdata[2:1])) else $error("format not taken");
    upper_zero_a: assert property ($past(reg_rd && reg_addr == urxb_pkg::OFS_DATA
        && char_size_sel < 3'h3) |-> (reg_rdata >> (4'h5 + {1'b0, $past(char_size_sel)})) == 8'h0)
        else $error("unused data bits set");
    empty_read_a: assert property ($past(reg_rd && reg_addr == urxb_pkg::OFS_DATA
        && !rx_enable) |-> reg_rdata == 8'h0) else $error("empty read not zero");
    // Main scenarios reached
    cover property (frame_valid && rx_enable && ie_r);
    cover property ($fell(rx_enable));
    cover property (rx_irq ##1 !rx_irq);
endmodule // urxb_chk

bind urxb_top urxb_chk #(.DEPTH(DEPTH)) u_chk (.mclk(mclk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_valid(frame_valid), .rx_enable(rx_enable), .rx_irq(rx_irq),
    .char_size_sel(char_size_sel), .parity_mode_sel(parity_mode_sel),
    .stop_bit_count_sel(stop_bit_count_sel));

// file: sim/urxb_far_end.sv
// Remote transmitter model feeding completed frames to the buffer
`timescale 1ns/1ps
module urxb_far_end (
    input wire logic mclk,
    input wire logic rst,
    input wire logic send,
    input wire logic [8:0] s_data,
    input wire logic s_stop,
    input wire logic s_odd,
    input wire logic s_bad,
    input wire logic s_start,
    output logic frame_valid,
    output logic [8:0] frame_data,
    output logic frame_stop_bit,
    output logic frame_parity_bit,
    output logic start_detect
);
    // One pulse per frame at its first stop bit; lines churn between frames
    always_ff @(posedge mclk) begin
        frame_valid <= send && !rst;
        start_detect <= s_start && !rst;
        if (send) begin
            frame_data <= s_data;
            frame_stop_bit <= s_stop;
            frame_parity_bit <= ^s_data[7:0] ^ s_odd ^ s_bad;
        end else begin
            frame_data <= rst ? 9'h000 : ~frame_data;
            frame_stop_bit <= rst ? 1'b0 : ~frame_stop_bit;
            frame_parity_bit <= rst ? 1'b0 : ~frame_parity_bit;
        end
    end
endmodule // urxb_far_end
